//--- core/bps_i2c_target.sv
module bps_i2c_target (
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  bps_reg_if.target  bus
);
  typedef enum logic [2:0] {
    BPS_IDLE = 3'b000,
    BPS_ADDR = 3'b001,
    BPS_PTR  = 3'b010,
    BPS_WDAT = 3'b011,
    BPS_RDAT = 3'b100
  } bps_i2c_st_t;

  bps_i2c_st_t st_ff;
  logic       scl_ff, sda_ff, ack_ff, done_ff, rw_ff, nack_ff, oe_ff;
  logic       wr_ff;
  logic [2:0] cnt_ff;
  logic [7:0] sh_ff, ptr_ff, waddr_ff, wdata_ff;

  wire rise  = scl_in && !scl_ff;
  wire fall  = !scl_in && scl_ff;
  wire start = scl_in && scl_ff && sda_ff && !sda_in;
  wire stop  = scl_in && scl_ff && !sda_ff && sda_in;
  wire rx    = (st_ff != BPS_IDLE) && (st_ff != BPS_RDAT);
  wire match = (sh_ff[7:1] == bps_pkg::I2C_ADDR);

  always_ff @(posedge sys_clk)
  begin
    scl_ff <= scl_in;
    sda_ff <= sda_in;
  end

  // multi byte writes
  // Address byte, pointer byte, then data bytes with auto increment
  always_ff @(posedge sys_clk)
  begin
    wr_ff <= 1'b0;
    if (sys_rst || stop)
    begin
      st_ff   <= BPS_IDLE;
      ack_ff  <= 1'b0;
      done_ff <= 1'b0;
      oe_ff   <= 1'b0;
      cnt_ff  <= 3'h0;
      if (sys_rst)
      begin
        ptr_ff   <= 8'h00;
        rw_ff    <= 1'b0;
        nack_ff  <= 1'b0;
        sh_ff    <= 8'h00;
        waddr_ff <= 8'h00;
        wdata_ff <= 8'h00;
      end
    end
    else if (start)
    begin
      st_ff   <= BPS_ADDR;
      ack_ff  <= 1'b0;
      done_ff <= 1'b0;
      oe_ff   <= 1'b0;
      cnt_ff  <= 3'h0;
    end
    else if (rise && st_ff != BPS_IDLE)
    begin
      if (ack_ff)
        nack_ff <= sda_in;
      else
      begin
        if (rx)
          sh_ff <= {sh_ff[6:0], sda_in};
        cnt_ff  <= cnt_ff + 3'h1;
        done_ff <= (cnt_ff == 3'h7);
      end
    end
    else if (fall && done_ff)
    begin
      done_ff <= 1'b0;
      ack_ff  <= 1'b1;
      oe_ff   <= rx && (st_ff != BPS_ADDR || match);
      unique case (st_ff)
        BPS_ADDR:
        begin
          rw_ff <= sh_ff[0];
          if (!match)
            st_ff <= BPS_IDLE;
        end
        BPS_PTR:  ptr_ff <= sh_ff;
        BPS_WDAT:
        begin
          wr_ff    <= 1'b1;
          waddr_ff <= ptr_ff;
          wdata_ff <= sh_ff;
          ptr_ff   <= ptr_ff + 8'h01;
        end
        BPS_RDAT: ptr_ff <= ptr_ff + 8'h01;
        BPS_IDLE: ack_ff <= 1'b0;
      endcase
    end
    else if (fall && ack_ff)
    begin
      ack_ff <= 1'b0;
      oe_ff  <= 1'b0;
      if (st_ff == BPS_ADDR)
        st_ff <= rw_ff ? BPS_RDAT : BPS_PTR;
      else if (st_ff == BPS_PTR)
        st_ff <= BPS_WDAT;
      // Controller's not-acknowledge ends a read burst
      if ((st_ff == BPS_ADDR && rw_ff) || (st_ff == BPS_RDAT && !nack_ff))
      begin
        sh_ff <= bus.rd_data;
        oe_ff <= !bus.rd_data[7];
      end
      else if (st_ff == BPS_RDAT)
        st_ff <= BPS_IDLE;
    end
    else if (fall && st_ff == BPS_RDAT)
    begin
      sh_ff <= {sh_ff[6:0], 1'b0};
      oe_ff <= !sh_ff[6];
    end
  end

  assign sda_out     = 1'b0;
  assign sda_oe      = oe_ff;
  assign bus.wr_stb  = wr_ff;
  assign bus.wr_addr = waddr_ff;
  assign bus.wr_data = wdata_ff;
  assign bus.rd_addr = ptr_ff;
endmodule : bps_i2c_target

//--- core/bps_minute_tick.sv
module bps_minute_tick #(
  parameter int CYC_PER_SEC = bps_pkg::CYC_PER_SEC
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  output logic      minute_tick
);
  localparam int SW = $clog2(CYC_PER_SEC);
  localparam logic [SW-1:0] SEC_LAST = SW'(CYC_PER_SEC - 1);
  localparam logic [5:0]    MIN_LAST = 6'(bps_pkg::MINUTE_S - 1);

  logic [SW-1:0] cyc_ff;
  logic [5:0]    sec_ff;
  logic          tick_ff;

  wire           sec_wrap = (cyc_ff == SEC_LAST);
  wire           min_wrap = sec_wrap && (sec_ff == MIN_LAST);
  wire [SW-1:0]  nxt_cyc  = sec_wrap ? '0 : cyc_ff + SW'(1);
  wire [5:0]     nxt_sec  = min_wrap ? 6'h00
                          : (sec_wrap ? sec_ff + 6'h01 : sec_ff);

  // free running
  // Never gated by run or by the calendar; only reset stops it
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cyc_ff  <= '0;
      sec_ff  <= 6'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cyc_ff  <= nxt_cyc;
      sec_ff  <= nxt_sec;
      tick_ff <= min_wrap;
    end
  end

  assign minute_tick = tick_ff;
endmodule : bps_minute_tick

//--- core/bps_scheduler.sv
module bps_scheduler #(
  parameter int CYC_PER_SEC = bps_pkg::CYC_PER_SEC
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic i2c_scl,
  input  wire logic i2c_sda_in,
  output logic      i2c_sda_out,
  output logic      i2c_sda_oe,
  output logic      host_power_on,
  output logic      basic_sched_sel,
  output logic      event_sched_sel,
  output logic      sched_running
);
  function automatic logic bps_in_range(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    bps_in_range = (v >= lo) && (v <= hi);
  endfunction : bps_in_range

  bps_reg_if reg_bus ();

  logic       minute_tick;
  logic [7:0] sel_ff, dur_ff, per_ff, cnt_ff;
  logic       run_ff, pwr_ff;
  logic [7:0] rem_dur_ff, rem_per_ff, rem_cnt_ff;

  bps_i2c_target u_target (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .scl_in  (i2c_scl),
    .sda_in  (i2c_sda_in),
    .sda_out (i2c_sda_out),
    .sda_oe  (i2c_sda_oe),
    .bus     (reg_bus)
  );

  bps_minute_tick #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_tick (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .minute_tick (minute_tick)
  );

  // Write decode
  wire [7:0] wd     = reg_bus.wr_data;
  wire       wr_sel = reg_bus.wr_stb && (reg_bus.wr_addr == bps_pkg::OFS_SEL);
  wire       wr_dur = reg_bus.wr_stb && (reg_bus.wr_addr == bps_pkg::OFS_DUR);
  wire       wr_per = reg_bus.wr_stb && (reg_bus.wr_addr == bps_pkg::OFS_PER);
  wire       wr_cnt = reg_bus.wr_stb && (reg_bus.wr_addr == bps_pkg::OFS_CNT);
  wire       wr_run = reg_bus.wr_stb && (reg_bus.wr_addr == bps_pkg::OFS_RUN);

  // locked while running
  // Selector is locked too, so the running scheduler cannot be swapped
  wire sel_ok = !run_ff && bps_in_range(wd, bps_pkg::SEL_BASIC,
                                        bps_pkg::SEL_EVENT);
  wire dur_ok = !run_ff && bps_in_range(wd, bps_pkg::VAL_MIN,
                                        bps_pkg::DUR_MAX);
  wire per_ok = !run_ff && bps_in_range(wd, bps_pkg::VAL_MIN,
                                        bps_pkg::VAL_MAX);
  wire cnt_ok = !run_ff && bps_in_range(wd, bps_pkg::VAL_MIN,
                                        bps_pkg::VAL_MAX);

  // one selection
  // A single stored code drives both selects, so they cannot overlap
  wire basic_sel = (sel_ff == bps_pkg::SEL_BASIC);

  // run values
  // Start only when the basic scheduler owns the host
  wire start_wr = wr_run && (wd == bps_pkg::RUN_ON) && !run_ff && basic_sel;
  wire stop_wr  = wr_run && (wd == bps_pkg::RUN_OFF);

  wire run_tick  = run_ff && minute_tick;
  wire dur_end   = run_tick && (rem_dur_ff == 8'h01);
  wire per_end   = run_tick && (rem_per_ff == 8'h01);
  wire unlimited = (rem_cnt_ff == bps_pkg::CNT_UNLIMITED);
  wire last_done = dur_end && !unlimited && (rem_cnt_ff == 8'h01);
  wire halt      = stop_wr || last_done;
  wire restart   = per_end && !halt;

  wire nxt_run = start_wr ? 1'b1 : (halt ? 1'b0 : run_ff);
  wire nxt_pwr = start_wr ? 1'b1
               : halt     ? 1'b0
               : restart  ? 1'b1
               : dur_end  ? 1'b0 : pwr_ff;

  wire [7:0] nxt_rem_dur = (start_wr || restart) ? dur_ff
                         : (run_tick && rem_dur_ff != 8'h00)
                           ? rem_dur_ff - 8'h01 : rem_dur_ff;
  wire [7:0] nxt_rem_per = (start_wr || restart) ? per_ff
                         : run_tick ? rem_per_ff - 8'h01 : rem_per_ff;
  wire [7:0] nxt_rem_cnt = start_wr ? cnt_ff
                         : (dur_end && !unlimited)
                           ? rem_cnt_ff - 8'h01 : rem_cnt_ff;

  wire [7:0] nxt_sel = (wr_sel && sel_ok) ? wd : sel_ff;
  wire [7:0] nxt_dur = (wr_dur && dur_ok) ? wd : dur_ff;
  wire [7:0] nxt_per = (wr_per && per_ok) ? wd : per_ff;
  wire [7:0] nxt_cnt = (wr_cnt && cnt_ok) ? wd : cnt_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sel_ff <= bps_pkg::RST_SEL;
      dur_ff <= bps_pkg::RST_DUR;
      per_ff <= bps_pkg::RST_PER;
      cnt_ff <= bps_pkg::RST_CNT;
      run_ff <= bps_pkg::RST_RUN[0];
      pwr_ff <= 1'b0;
    end
    else
    begin
      sel_ff <= nxt_sel;
      dur_ff <= nxt_dur;
      per_ff <= nxt_per;
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      pwr_ff <= nxt_pwr;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rem_dur_ff <= 8'h00;
      rem_per_ff <= 8'h00;
      rem_cnt_ff <= 8'h00;
    end
    else
    begin
      rem_dur_ff <= nxt_rem_dur;
      rem_per_ff <= nxt_rem_per;
      rem_cnt_ff <= nxt_rem_cnt;
    end
  end

  // live readback
  // Programmed values show again once the scheduler stops
  wire [7:0] ra      = reg_bus.rd_addr;
  wire [7:0] rd_dur  = run_ff ? rem_dur_ff : dur_ff;
  wire [7:0] rd_per  = run_ff ? rem_per_ff : per_ff;
  wire [7:0] rd_cnt  = run_ff ? rem_cnt_ff : cnt_ff;
  wire [7:0] rd_run  = run_ff ? bps_pkg::RUN_ON : bps_pkg::RUN_OFF;
  assign reg_bus.rd_data = (ra == bps_pkg::OFS_SEL) ? sel_ff
                         : (ra == bps_pkg::OFS_DUR) ? rd_dur
                         : (ra == bps_pkg::OFS_PER) ? rd_per
                         : (ra == bps_pkg::OFS_CNT) ? rd_cnt
                         : (ra == bps_pkg::OFS_RUN) ? rd_run : 8'h00;

  assign host_power_on   = pwr_ff;
  assign basic_sched_sel = basic_sel;
  assign event_sched_sel = (sel_ff == bps_pkg::SEL_EVENT);
  assign sched_running   = run_ff;

  sel_exclusive_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      !(basic_sched_sel && event_sched_sel))
    else $error("both schedulers selected");

  sel_decode_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_sel && !run_ff && wd == 8'h01) |=> event_sched_sel && !basic_sel)
    else $error("select 0x01 did not pick the event scheduler");

  power_edge_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(host_power_on) |-> $past(start_wr || minute_tick))
    else $error("power-on away from a minute boundary");

  start_now_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      start_wr |=> host_power_on && sched_running && rem_dur_ff == dur_ff)
    else $error("run write did not start at once");

  dur_off_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dur_end && !per_end) |=> !host_power_on ##1 $stable(host_power_on))
    else $error("host not off at end of on-duration");

  period_on_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      restart |=> host_power_on && rem_per_ff == per_ff)
    else $error("period end did not restart the host");

  locked_regs_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (run_ff && reg_bus.wr_stb) |=> $stable(dur_ff) && $stable(per_ff)
        && $stable(cnt_ff) && $stable(sel_ff))
    else $error("register changed while running");

  dur_range_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      dur_ff >= 8'h01 && dur_ff <= 8'hFE && per_ff != 8'h00
        && cnt_ff != 8'h00)
    else $error("programmed value out of range");

  last_stop_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      last_done |=> !sched_running && !host_power_on ##1 !host_power_on)
    else $error("scheduler did not idle after last cycle");

  unlimited_keep_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (run_ff && unlimited && !stop_wr) |=> run_ff && rem_cnt_ff == 8'hFF)
    else $error("unlimited count changed or stopped");

  count_down_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dur_end && !unlimited && !halt)
        |=> rem_cnt_ff == $past(rem_cnt_ff) - 8'h01)
    else $error("remaining count did not decrease");

  run_value_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_run && wd > 8'h01 && !last_done) |=> run_ff == $past(run_ff))
    else $error("illegal run value was taken");

  dur_reset_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> dur_ff == 8'h01)
    else $error("on-duration reset value wrong");

  per_reset_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> per_ff == 8'h02)
    else $error("period reset value wrong");

  cnt_reset_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> cnt_ff == 8'h01)
    else $error("repeat count reset value wrong");

  run_reset_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> !sched_running && sel_ff == 8'h00)
    else $error("run or select reset value wrong");

  stop_now_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      stop_wr |=> !sched_running && !host_power_on)
    else $error("run clear did not stop the host");

  dur_write_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_dur && !run_ff && wd >= 8'h01 && wd <= 8'hFE)
        |=> dur_ff == $past(wd))
    else $error("legal on-duration not stored");

  dur_refuse_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_dur && (wd == 8'h00 || wd == 8'hFF)) |=> $stable(dur_ff))
    else $error("illegal on-duration stored");

  per_write_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_per && !run_ff && wd != 8'h00) |=> per_ff == $past(wd))
    else $error("legal period not stored");

  per_refuse_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_per && wd == 8'h00) |=> $stable(per_ff))
    else $error("zero period stored");

  cnt_write_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_cnt && !run_ff && wd != 8'h00) |=> cnt_ff == $past(wd))
    else $error("legal repeat count not stored");

  cnt_refuse_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_cnt && wd == 8'h00) |=> $stable(cnt_ff))
    else $error("zero repeat count stored");

  sel_refuse_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_sel && wd > 8'h01) |=> $stable(sel_ff))
    else $error("illegal select value stored");

  dur_down_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (run_tick && rem_dur_ff > 8'h01 && !restart && !halt)
        |=> rem_dur_ff == $past(rem_dur_ff) - 8'h01)
    else $error("remaining on-duration did not count down");

  per_down_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (run_tick && !per_end && !halt)
        |=> rem_per_ff == $past(rem_per_ff) - 8'h01)
    else $error("remaining period did not count down");

  rem_hold_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (run_ff && !minute_tick && !stop_wr) |=> $stable(rem_dur_ff)
        && $stable(rem_per_ff) && $stable(host_power_on))
    else $error("timed action away from a minute boundary");

  cnt_load_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      start_wr |=> rem_cnt_ff == $past(cnt_ff))
    else $error("repeat count not loaded at start");

  idle_off_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sched_running |-> !host_power_on)
    else $error("host powered while scheduler idle");

  start_refuse_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_run && wd == 8'h01 && sel_ff == 8'h01) |=> !sched_running)
    else $error("basic scheduler ran while event selected");

  on_hold_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (run_ff && host_power_on && rem_dur_ff > 8'h01 && !stop_wr)
        |=> host_power_on)
    else $error("host dropped before on-duration ended");
endmodule : bps_scheduler

//--- include/bps_pkg.sv
package bps_pkg;
  // Target address on the two-wire bus
  localparam logic [6:0] I2C_ADDR      = 7'h6B;
  // Register offsets
  localparam logic [7:0] OFS_SEL       = 8'h19;
  localparam logic [7:0] OFS_DUR       = 8'h1A;
  localparam logic [7:0] OFS_PER       = 8'h1B;
  localparam logic [7:0] OFS_CNT       = 8'h1C;
  localparam logic [7:0] OFS_RUN       = 8'h1D;
  // Values after reset
  localparam logic [7:0] RST_SEL       = 8'h00;
  localparam logic [7:0] RST_DUR       = 8'h01;
  localparam logic [7:0] RST_PER       = 8'h02;
  localparam logic [7:0] RST_CNT       = 8'h01;
  localparam logic [7:0] RST_RUN       = 8'h00;
  // Encodings and limits
  localparam logic [7:0] SEL_BASIC     = 8'h00;
  localparam logic [7:0] SEL_EVENT     = 8'h01;
  localparam logic [7:0] RUN_OFF       = 8'h00;
  localparam logic [7:0] RUN_ON        = 8'h01;
  localparam logic [7:0] VAL_MIN       = 8'h01;
  localparam logic [7:0] DUR_MAX       = 8'hFE;
  localparam logic [7:0] VAL_MAX       = 8'hFF;
  localparam logic [7:0] CNT_UNLIMITED = 8'hFF;
  // Timing: clock rate, one second, seconds per minute
  localparam int         CLK_HZ        = 100_000_000;
  localparam int         SECOND_S      = 1;
  localparam int         MINUTE_S      = 60;
  localparam int         CYC_PER_SEC   = CLK_HZ * SECOND_S;
endpackage : bps_pkg

//--- include/bps_reg_if.sv
interface bps_reg_if;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport target (output wr_stb, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
  modport regs   (input wr_stb, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface : bps_reg_if

//--- verification/bps_host_model.sv
module bps_host_model #(
  parameter int PHASE = 5
) (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idles high and stands still outside frames
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold();
    repeat (PHASE) @(posedge sys_clk);
  endtask : hold

  task automatic bit_io(input logic b, output logic r);
    @(posedge sys_clk);
    sda_low <= ~b;
    hold();
    scl <= 1'b1;
    hold();
    r = sda_line;
    scl <= 1'b0;
  endtask : bit_io

  task automatic frame_start(input logic again);
    @(posedge sys_clk);
    if (again)
    begin
      sda_low <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
    end
    sda_low <= 1'b1;
    hold();
    scl <= 1'b0;
  endtask : frame_start

  task automatic frame_stop();
    @(posedge sys_clk);
    sda_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask : frame_stop

  // Ninth slot is released: ack on writes, NACK on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask : xfer

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] val, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    frame_start(1'b0);
    xfer({dev, 1'b0}, q, a0);
    xfer(ofs, q, a1);
    xfer(val, q, a2);
    frame_stop();
    ok = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val,
                          output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    frame_start(1'b0);
    xfer({bps_pkg::I2C_ADDR, 1'b0}, q, a0);
    xfer(ofs, q, a1);
    frame_start(1'b1);
    xfer({bps_pkg::I2C_ADDR, 1'b1}, q, a2);
    xfer(8'hFF, val, a3);
    frame_stop();
    ok = a0 & a1 & a2;
  endtask : read_reg
endmodule : bps_host_model

//--- verification/bps_scheduler_tb.sv
module bps_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPS = 10;
  localparam int MIN = 60 * CPS;

  logic       sys_clk;
  logic       sys_rst;
  logic       i2c_scl;
  logic       host_sda_low;
  logic       i2c_sda_out;
  logic       i2c_sda_oe;
  logic       host_power_on;
  logic       basic_sched_sel;
  logic       event_sched_sel;
  logic       sched_running;
  wire logic  sda_line;
  logic       pwr_seen = 1'b0;
  logic       ok;
  logic [7:0] q;
  int         err_count;
  int         n_tests;
  int         cyc = 0;
  int         ev[$];
  // Offset, written value, value read back
  logic [23:0] rng [9] = '{24'h1A_FF_01, 24'h1A_FE_FE, 24'h1A_00_FE,
                           24'h1B_00_02, 24'h1B_FF_FF, 24'h1C_00_01,
                           24'h1D_02_00, 24'h19_02_00, 24'h1E_55_00};

  // Open-drain line with pull-up
  assign sda_line = (i2c_sda_oe ? i2c_sda_out : 1'b1) & ~host_sda_low;

  bps_scheduler #(.CYC_PER_SEC(CPS)) bps_scheduler_i (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .i2c_scl         (i2c_scl),
    .i2c_sda_in      (sda_line),
    .i2c_sda_out     (i2c_sda_out),
    .i2c_sda_oe      (i2c_sda_oe),
    .host_power_on   (host_power_on),
    .basic_sched_sel (basic_sched_sel),
    .event_sched_sel (event_sched_sel),
    .sched_running   (sched_running)
  );

  bps_host_model bps_host_model_i (
    .sys_clk  (sys_clk),
    .sda_line (sda_line),
    .scl      (i2c_scl),
    .sda_low  (host_sda_low)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Cycle stamps of every host power change
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    pwr_seen <= host_power_on;
    if (host_power_on !== pwr_seen)
      ev.push_back(cyc);
  end

  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic gap(input int i, input int j, input int mins);
    n_tests++;
    if (ev.size() <= j || ev[j] - ev[i] != mins * MIN)
    begin
      err_count++;
      $display("ERROR %0t: power gap %0d to %0d wrong", $time, i, j);
    end
  endtask : gap

  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    bps_host_model_i.write_reg(bps_pkg::I2C_ADDR, ofs, val, ok);
    check(8'(ok), 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    bps_host_model_i.read_reg(ofs, q, ok);
    check(8'(ok), 8'h01);
    check(q, exp);
  endtask : rd

  // Bounded wait, sampled after the edge has settled
  task automatic wait_pwr(input logic v);
    int n;
    n = 0;
    while (host_power_on !== v && n < 3 * MIN)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    // Let the event recorder stamp the change first
    @(posedge sys_clk);
    #1;
    check(8'(host_power_on), 8'(v));
  endtask : wait_pwr

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check(8'({basic_sched_sel, event_sched_sel}), 8'h02);
    check(8'({host_power_on, sched_running}), 8'h00);
    rd(bps_pkg::OFS_SEL, 8'h00);
    rd(bps_pkg::OFS_DUR, 8'h01);
    rd(bps_pkg::OFS_PER, 8'h02);
    rd(bps_pkg::OFS_CNT, 8'h01);
    rd(bps_pkg::OFS_RUN, 8'h00);
    bps_host_model_i.write_reg(bps_pkg::I2C_ADDR ^ 7'h01,
                               bps_pkg::OFS_DUR, 8'h07, ok);
    check(8'(ok), 8'h00);
    rd(bps_pkg::OFS_DUR, 8'h01);
    // selecting one scheduler drops the other
    wr(bps_pkg::OFS_SEL, 8'h01);
    check(8'({basic_sched_sel, event_sched_sel}), 8'h01);
    wr(bps_pkg::OFS_RUN, 8'h01);
    rd(bps_pkg::OFS_RUN, 8'h00);
    check(8'(host_power_on), 8'h00);
    wr(bps_pkg::OFS_SEL, 8'h00);
    check(8'({basic_sched_sel, event_sched_sel}), 8'h02);
    // Range limits of every register
    foreach (rng[i])
    begin
      wr(rng[i][23:16], rng[i][15:8]);
      rd(rng[i][23:16], rng[i][7:0]);
    end
    // host programs and verifies before starting
    wr(bps_pkg::OFS_DUR, 8'h01);
    wr(bps_pkg::OFS_PER, 8'h02);
    wr(bps_pkg::OFS_CNT, 8'h02);
    rd(bps_pkg::OFS_CNT, 8'h02);
    ev.delete();
    wr(bps_pkg::OFS_RUN, 8'h01);
    check(8'({host_power_on, sched_running}), 8'h03);
    wait_pwr(1'b0);
    rd(bps_pkg::OFS_PER, 8'h01);
    rd(bps_pkg::OFS_CNT, 8'h01);
    wait_pwr(1'b1);
    wait_pwr(1'b0);
    check(8'(sched_running), 8'h00);
    rd(bps_pkg::OFS_RUN, 8'h00);
    repeat (MIN + 100) @(posedge sys_clk);
    check(8'(ev.size()), 8'h04);
    // First on-time is cut by the tick phase; measure tick to tick
    gap(1, 3, 2);
    gap(1, 2, 1);
    gap(2, 3, 1);
    // Unlimited count, locked registers, run cleared
    wr(bps_pkg::OFS_DUR, 8'h02);
    wr(bps_pkg::OFS_PER, 8'h03);
    wr(bps_pkg::OFS_CNT, 8'hFF);
    ev.delete();
    wr(bps_pkg::OFS_RUN, 8'h01);
    wait_pwr(1'b0);
    rd(bps_pkg::OFS_PER, 8'h01);
    rd(bps_pkg::OFS_CNT, 8'hFF);
    wait_pwr(1'b1);
    rd(bps_pkg::OFS_DUR, 8'h02);
    wr(bps_pkg::OFS_DUR, 8'h05);
    wr(bps_pkg::OFS_SEL, 8'h01);
    check(8'(basic_sched_sel), 8'h01);
    wait_pwr(1'b0);
    wait_pwr(1'b1);
    gap(1, 3, 3);
    gap(2, 3, 2);
    gap(3, 4, 1);
    wr(bps_pkg::OFS_RUN, 8'h00);
    check(8'({host_power_on, sched_running}), 8'h00);
    rd(bps_pkg::OFS_DUR, 8'h02);
    rd(bps_pkg::OFS_CNT, 8'hFF);
    end_of_test();
  end
endmodule : bps_scheduler_tb
